// ==== hw/ims_irq_mask_status.sv ====
// ims_irq_mask_status: enable mask, status flags and request output.
// assumes the protocol engine supplies one-cycle event pulses and
// level status inputs synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - unused upper bits read zero, ignore writes
// - mask bit 6 gates addressed-as-slave request
// - mask bit 5 gates stop-seen request
// - mask bit 4 gates tx-data-ready request
// - mask bit 3 gates rx-data-ready request
// - mask bit 2 gates regs-access-ready request
// - mask bit 1 gates no-ack request
// - mask bit 0 gates arbitration-lost request
// - bits 14-12 and 5-0 write-one-clear
// - fixed status register bit layout
// - reset: tx shift empty, tx ready one
// - loopback holds slave direction at zero
// - direction clears on start or stop
// - direction one only as slave transmitter
// - noack sent sets on noackSentSet, w1c clears
// - bus busy clears on stop or w1c
module ims_irq_mask_status (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic [ims_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [ims_pkg::DATA_W-1:0] regWdata,
   input  wire logic                       regWrite,
   input  wire logic                       regRead,
   output var  logic [ims_pkg::DATA_W-1:0] regRdata,
   input  wire logic                       arbitrationLostSet,
   input  wire logic                       noAckEventSet,
   input  wire logic                       regsAccessReadySet,
   input  wire logic                       rxDataReadySet,
   input  wire logic                       txDataReadySet,
   input  wire logic                       stopSeenSet,
   input  wire logic                       startSeen,
   input  wire logic                       slaveTxActive,
   input  wire logic                       noackSentSet,
   input  wire logic                       busBusySet,
   input  wire logic                       rxShiftFull,
   input  wire logic                       txShiftEmpty,
   input  wire logic                       addressedAsSlave,
   input  wire logic                       zeroAddressSeen,
   input  wire logic                       digitalLoopback,
   output var  logic                       irqRequest
);
   logic [6:0]                   irqEnableMask;
   logic [5:0]                   eventFlag;
   logic [5:0]                   eventSet;
   logic                         slaveTxDirection;
   logic                         noackSent;
   logic                         busBusy;
   logic                         wrEnable;
   logic                         wrStatus;
   logic [ims_pkg::DATA_W-1:0]   statusWord;
   logic [ims_pkg::DATA_W-1:0]   next_regRdata;
   logic                         txShiftEmptyReg;
   logic                         addrSlaveReg;
   logic                         rxShiftFullReg;
   logic                         zeroAddrReg;

   assign wrEnable = regWrite && (regAddr == ims_pkg::OFF_ENABLE);
   assign wrStatus = regWrite && (regAddr == ims_pkg::OFF_STATUS);

   // only low seven mask bits stored
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqEnableMask <= ims_pkg::ENABLE_RESET;
      end else if (wrEnable) begin
         irqEnableMask <= regWdata[6:0] & ims_pkg::ENABLE_MASK;
      end
   end

   assign eventSet[ims_pkg::BIT_ARB_LOST]  = arbitrationLostSet;
   assign eventSet[ims_pkg::BIT_NO_ACK]    = noAckEventSet;
   assign eventSet[ims_pkg::BIT_REGS_RDY]  = regsAccessReadySet;
   assign eventSet[ims_pkg::BIT_RX_RDY]    = rxDataReadySet;
   assign eventSet[ims_pkg::BIT_TX_RDY]    = txDataReadySet;
   assign eventSet[ims_pkg::BIT_STOP_SEEN] = stopSeenSet;

   // tx ready flag resets to one
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : gFlag
         ims_w1c_bit #(
            .RESET_VAL (ims_pkg::FLAGS_RESET[gi])
         ) uFlag (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .setPulse   (eventSet[gi]),
            .clearPulse (wrStatus && regWdata[gi]),
            .flag       (eventFlag[gi])
         );
      end
   endgenerate

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slaveTxDirection <= 1'b0;
      end else if (digitalLoopback) begin
         slaveTxDirection <= 1'b0;
      end else if (slaveTxActive) begin
         slaveTxDirection <= 1'b1;
      end else if (startSeen || stopSeenSet) begin
         slaveTxDirection <= 1'b0;
      end else if (wrStatus && regWdata[ims_pkg::BIT_SLAVE_DIR]) begin
         slaveTxDirection <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         noackSent <= 1'b0;
      end else if (noackSentSet) begin
         noackSent <= 1'b1;
      end else if (wrStatus && regWdata[ims_pkg::BIT_NOACK_SENT]) begin
         noackSent <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busBusy <= 1'b0;
      end else if (busBusySet) begin
         busBusy <= 1'b1;
      end else if (stopSeenSet) begin
         busBusy <= 1'b0;
      end else if (wrStatus && regWdata[ims_pkg::BIT_BUS_BUSY]) begin
         busBusy <= 1'b0;
      end
   end

   // tx shift empty resets to one
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         txShiftEmptyReg <= 1'b1;
         rxShiftFullReg  <= 1'b0;
         addrSlaveReg    <= 1'b0;
         zeroAddrReg     <= 1'b0;
      end else begin
         txShiftEmptyReg <= txShiftEmpty;
         rxShiftFullReg  <= rxShiftFull;
         addrSlaveReg    <= addressedAsSlave;
         zeroAddrReg     <= zeroAddressSeen;
      end
   end

   // bits 31-15 and 7-6 read zero
   always_comb begin
      statusWord                          = '0;
      statusWord[5:0]                     = eventFlag;
      statusWord[ims_pkg::BIT_ZERO_ADDR]  = zeroAddrReg;
      statusWord[ims_pkg::BIT_ADDR_SLV_S] = addrSlaveReg;
      statusWord[ims_pkg::BIT_TX_SH_EMPT] = txShiftEmptyReg;
      statusWord[ims_pkg::BIT_RX_SH_FULL] = rxShiftFullReg;
      statusWord[ims_pkg::BIT_BUS_BUSY]   = busBusy;
      statusWord[ims_pkg::BIT_NOACK_SENT] = noackSent;
      statusWord[ims_pkg::BIT_SLAVE_DIR]  = slaveTxDirection;
   end

   // unmapped offsets read zero, no error path
   always_comb begin
      next_regRdata = '0;
      if (regRead) begin
         case (regAddr)
            ims_pkg::OFF_ENABLE: begin
               next_regRdata = {25'h0000000, irqEnableMask};
            end
            ims_pkg::OFF_STATUS: begin
               next_regRdata = statusWord;
            end
            default: begin
               next_regRdata = '0;
            end
         endcase
      end
   end

   // data valid only the cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdata <= '0;
      end else begin
         regRdata <= next_regRdata;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqRequest <= 1'b0;
      end else begin
         irqRequest <= |(eventFlag & irqEnableMask[5:0])
                     | (addrSlaveReg & irqEnableMask[ims_pkg::BIT_ADDR_SLAVE]);
      end
   end
endmodule
`default_nettype wire

// ==== hw/ims_pkg.sv ====
// ims_pkg: register map, field positions and reset values of the
// interrupt enable mask and status flag block.
// assumes a 32-bit word register port with byte offsets.
package ims_pkg;
   localparam int          DATA_W         = 32;
   localparam int          ADDR_W         = 8;
   localparam int          EVENT_W        = 7;
   localparam int          STATUS_W       = 15;
   localparam logic [7:0]  OFF_ENABLE     = 8'h04;
   localparam logic [7:0]  OFF_STATUS     = 8'h08;
   // event positions, 0-5 shared by enable mask and status, 6 mask only
   localparam int          BIT_ARB_LOST   = 0;
   localparam int          BIT_NO_ACK     = 1;
   localparam int          BIT_REGS_RDY   = 2;
   localparam int          BIT_RX_RDY     = 3;
   localparam int          BIT_TX_RDY     = 4;
   localparam int          BIT_STOP_SEEN  = 5;
   localparam int          BIT_ADDR_SLAVE = 6;
   // status-only positions
   localparam int          BIT_ZERO_ADDR  = 8;
   localparam int          BIT_ADDR_SLV_S = 9;
   localparam int          BIT_TX_SH_EMPT = 10;
   localparam int          BIT_RX_SH_FULL = 11;
   localparam int          BIT_BUS_BUSY   = 12;
   localparam int          BIT_NOACK_SENT = 13;
   localparam int          BIT_SLAVE_DIR  = 14;
   localparam logic [6:0]  ENABLE_RESET   = 7'h00;
   localparam logic [5:0]  FLAGS_RESET    = 6'h10;
   localparam logic [6:0]  ENABLE_MASK    = 7'h7f;
endpackage

// ==== hw/ims_w1c_bit.sv ====
// ims_w1c_bit: one sticky flag, hardware set, software write-1 clear.
// assumes set and clear are single-cycle synchronous pulses.
`timescale 1ns/1ps
`default_nettype none
module ims_w1c_bit #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic setPulse,
   input  wire logic clearPulse,
   output var  logic flag
);
   // set wins so an event in the clear cycle is kept
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag <= RESET_VAL;
      end else if (setPulse) begin
         flag <= 1'b1;
      end else if (clearPulse) begin
         flag <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== tb/ims_chk_asserts.sv ====
// ims_chk: port-level checks of the mask and status block.
// assumes strobes never both high in one cycle.
`timescale 1ns/1ps
`default_nettype none
module ims_chk (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  regAddr,
   input wire logic [31:0] regWdata,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [31:0] regRdata,
   input wire logic        txDataReadySet,
   input wire logic        digitalLoopback,
   input wire logic        irqRequest
);
   logic [6:0] en;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // shadow of the mask, from bus writes only
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst) en <= 7'h0;
      else if (regWrite && regAddr == 8'h04) en <= regWdata[6:0];
   chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
      else $error("read data not idle");
   chk_mask_upper: assert property ($past(regRead) && $past(regAddr) == 8'h04
      |-> regRdata[31:7] == 25'h0) else $error("mask upper bits set");
   chk_status_gaps: assert property ($past(regRead) && $past(regAddr) == 8'h08
      |-> regRdata[31:15] == 17'h0 && regRdata[7:6] == 2'h0) else $error("status gap set");
   chk_unmapped_zero: assert property ($past(regRead) && $past(regAddr) != 8'h04
      && $past(regAddr) != 8'h08 |-> regRdata == 32'h0) else $error("unmapped read");
   chk_mask_readback: assert property ($past(regRead) && $past(regAddr) == 8'h04
      |-> regRdata[6:0] == en) else $error("mask readback");
   chk_loopback_dir: assert property ($past(regRead) && $past(regAddr) == 8'h08
      && $past(digitalLoopback, 2) && $past(digitalLoopback) |-> !regRdata[14])
      else $error("direction set in loopback");
   chk_masked_quiet: assert property (en == 7'h0 |=> !irqRequest)
      else $error("request while masked");
   chk_tx_raise: assert property (txDataReadySet && en[4] && !regWrite ##1 !regWrite
      |-> ##1 irqRequest) else $error("no request on tx ready");
endmodule
bind ims_irq_mask_status ims_chk chk_u (.clk(clk), .sys_rst(sys_rst),
   .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
   .regRdata(regRdata), .txDataReadySet(txDataReadySet),
   .digitalLoopback(digitalLoopback), .irqRequest(irqRequest));
`default_nettype wire

// ==== tb/ims_host_model.sv ====
// ims_host_model: host side of the register port.
// assumes read data stands only in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module ims_host_model (
   input  wire logic        clk,
   output var  logic [7:0]  regAddr,
   output var  logic [31:0] regWdata,
   output var  logic        regWrite,
   output var  logic        regRead,
   input  wire logic [31:0] regRdata
);
   initial begin
      regAddr = 8'h0;
      regWdata = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   // released lines show inverted values, not stale ones
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      #1;
      v = regRdata;
   endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// tb: self-checking bench of the mask and status block.
// assumes the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  regAddr;
   logic [31:0] regWdata, regRdata, d, r;
   logic        regWrite, regRead, irqRequest;
   logic [9:0]  pl = 10'h0;
   logic [3:0]  lv = 4'h4;
   logic        digital_loopback = 1'b0;
   logic [31:0] seed = 32'h339b;
   int          n_errors = 0;
   int          comparisons = 0;
   always #5 clk = ~clk;
   ims_host_model host_u (.clk(clk), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
   ims_irq_mask_status dut_u (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .arbitrationLostSet(pl[0]), .noAckEventSet(pl[1]), .regsAccessReadySet(pl[2]),
      .rxDataReadySet(pl[3]), .txDataReadySet(pl[4]), .stopSeenSet(pl[5]),
      .startSeen(pl[6]), .noackSentSet(pl[7]), .busBusySet(pl[8]), .slaveTxActive(pl[9]),
      .rxShiftFull(lv[3]), .txShiftEmpty(lv[2]), .addressedAsSlave(lv[1]),
      .zeroAddressSeen(lv[0]), .digitalLoopback(digital_loopback), .irqRequest(irqRequest));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] stat(input logic [5:0] f, input logic [2:0] h);
      return {17'h0, h, lv, 2'b00, f};
   endfunction
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      host_u.rd(a, d);
      `CHK(d, e)
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      pl <= 10'h1 << i;
      @(posedge clk);
      pl <= 10'h0;
   endtask
   task automatic wt;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      results;
   end
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(8'h04, 32'h0);
      rdc(8'h08, stat(6'h10, 3'h0));
      host_u.wr(8'h04, 32'hffffffff);
      rdc(8'h04, 32'h7f);
      rdc(8'h0c, 32'h0);
      wt;
      `CHK(irqRequest, 1'b1)
      host_u.wr(8'h08, 32'hffffffff);
      rdc(8'h08, stat(6'h0, 3'h0));
      for (int i = 0; i < 6; i++) begin
         host_u.wr(8'h04, 32'h1 << i);
         pulse((i + 1) % 6);
         wt;
         `CHK(irqRequest, 1'b0)
         pulse(i);
         rdc(8'h08, stat(6'(1 << i) | 6'(1 << ((i + 1) % 6)), 3'h0));
         `CHK(irqRequest, 1'b1)
         host_u.wr(8'h08, 32'h3f);
         wt;
         `CHK(irqRequest, 1'b0)
      end
      // addressed-as-slave gated by mask bit 6
      @(posedge clk) lv <= 4'h6;
      host_u.wr(8'h04, 32'h40);
      wt;
      `CHK(irqRequest, 1'b1)
      host_u.wr(8'h04, 32'h3f);
      wt;
      `CHK(irqRequest, 1'b0)
      pulse(7);
      pulse(8);
      pulse(9);
      rdc(8'h08, stat(6'h0, 3'h7));
      pulse(6);
      rdc(8'h08, stat(6'h0, 3'h3));
      host_u.wr(8'h08, 32'h2000);
      pulse(5);
      rdc(8'h08, stat(6'h20, 3'h0));
      @(posedge clk) digital_loopback <= 1'b1;
      pulse(9);
      host_u.wr(8'h08, 32'h0);
      rdc(8'h08, stat(6'h20, 3'h0));
      digital_loopback <= 1'b0;
      for (int k = 0; k < 16; k++) begin
         r = xs();
         @(posedge clk) lv <= r[11:8];
         host_u.wr(8'h04, r);
         rdc(8'h04, r & 32'h7f);
         rdc(8'h08, stat(6'h20, 3'h0));
         wt;
         `CHK(irqRequest, r[5] | (r[9] & r[6]))
      end
      results;
   end
endmodule
`default_nettype wire
